// *** hw/rx_props_pkg.sv ***
// constants for the receiver property bank: offsets, fields, resets, limits
// assumes a 16-bit property address and 16-bit property data
package rx_props_pkg;

  // property addresses
  localparam logic [15:0] ADDR_IRQ_SOURCE   = 16'h0001;
  localparam logic [15:0] ADDR_REF_FREQ     = 16'h0201;
  localparam logic [15:0] ADDR_REF_DIVIDER  = 16'h0202;
  localparam logic [15:0] ADDR_TUNE_LIMIT   = 16'h5108;

  // reset values
  localparam logic [15:0] RST_IRQ_SOURCE    = 16'h0000;
  localparam logic [15:0] RST_REF_FREQ      = 16'h8000;
  localparam logic [11:0] RST_REF_DIVIDER   = 12'h001;
  localparam logic [15:0] RST_TUNE_LIMIT    = 16'h000A;

  // interrupt source register layout
  localparam logic [15:0] IRQ_WRITE_MASK    = 16'h0FCF;
  localparam logic [15:0] IRQ_ALERT_BITS    = 16'h0404;
  localparam logic [7:0]  IRQ_SQ_ENABLE     = 8'h08;
  localparam int          BIT_ACCEPT        = 7;
  localparam int          BIT_ERROR         = 6;
  localparam int          REPEAT_LSB        = 8;
  localparam int          REPEAT_MSB        = 11;

  // status byte bits that exist
  localparam logic [7:0]  STATUS_USED       = 8'hCF;

  // reference frequency field, in hertz
  localparam logic [15:0] REF_FREQ_OFF      = 16'h0000;
  localparam logic [15:0] REF_FREQ_MIN      = 16'h799A;
  localparam logic [15:0] REF_FREQ_MAX      = 16'h8666;

  // divider field
  localparam int          DIVIDER_W         = 12;
  localparam logic [11:0] DIVIDER_MIN       = 12'h001;

  // tune error limit field, in kilohertz
  localparam logic [15:0] TUNE_LIMIT_MAX    = 16'h000F;

endpackage

// *** hw/ref_divider.sv ***
// divides the sampled external reference clock by an integer count
// assumes ext_ref_in is synchronous to sys_clk_in and slower than half of it
module ref_divider #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // external reference and divide count
  input  wire logic             ext_ref_in,
  input  wire logic [WIDTH-1:0] divide_in,
  // one pulse per divided period
  output logic                  tick_out
);

  initial begin
    if (WIDTH < 1 || WIDTH > 16) begin
      $error("ref_divider: WIDTH out of range");
    end
  end

  logic             ref_prev_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             tick_q;
  logic             tick_d;

  // rising edge of the reference and end of a divided period
  wire ref_rise = ext_ref_in & ~ref_prev_q;
  wire last_edge = ref_rise & (count_q + 1'b1 >= divide_in);

  // count edges, restart at the programmed divide count
  assign count_d = last_edge ? '0
                 : (ref_rise ? count_q + 1'b1 : count_q);
  assign tick_d  = last_edge;

  // edge history, counter and tick
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_prev_q <= 1'b0;
      count_q    <= '0;
      tick_q     <= 1'b0;
    end else begin
      ref_prev_q <= ext_ref_in;
      count_q    <= count_d;
      tick_q     <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule

// *** hw/rx_props.sv ***
// receiver property bank: interrupt sources, reference divider, tune limit
// assumes the command engine presents one property access at a time,
// pulses status events, and samples the external reference synchronously
//
// Overview of operation
// - only used status byte bits drive interrupt
// - flag is set before its interrupt
// - accept enable loaded by power-up, rewritable
// - error interrupt enable, resets to zero
// - signal quality interrupt enable, resets zero
// - alert enable, resets zero, variant only
// - audio quality interrupt enable, resets zero
// - tune done interrupt enable, resets zero
// - repeat bits allow interrupt on set flag
// - revision 2.0 ignores signal quality enable
// - accept flag set when next command possible
// - reference frequency 31130..34406 or zero disables
// - internal reference is external divided by prescale
// - rail indicator when error exceeds limit
// - interrupt overrides general output on pin
module rx_props #(
  parameter bit HAS_ALERT   = 1'b1,
  parameter bit WB_REV_2P0  = 1'b0,
  parameter int DIVIDER_W   = rx_props_pkg::DIVIDER_W
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // power state and power-up command
  input  wire logic        powered_up_in,
  input  wire logic        powerup_cmd_in,
  input  wire logic        powerup_accept_en_in,
  // property access
  input  wire logic        prop_wr_in,
  input  wire logic        prop_rd_in,
  input  wire logic [15:0] prop_addr_in,
  input  wire logic [15:0] prop_wdata_in,
  output logic      [15:0] prop_rdata_out,
  output logic             prop_done_out,
  // status events and acknowledges, status byte layout
  input  wire logic [7:0]  event_set_in,
  input  wire logic [7:0]  status_clear_in,
  output logic      [7:0]  status_out,
  // shared interrupt / general output pin
  input  wire logic        gpo_enable_in,
  input  wire logic        gpo_level_in,
  output logic             irq_pin_out,
  output logic             irq_pin_oe_out,
  // reference clock path
  input  wire logic        ext_ref_clk_in,
  output logic             ref_tick_out,
  output logic             correction_enable_out,
  // frequency correction monitor
  input  wire logic [15:0] tune_error_in,
  output logic             rail_out
);

  initial begin
    if (DIVIDER_W != rx_props_pkg::DIVIDER_W) begin
      $error("rx_props: divider width must match the field");
    end
  end

  // legal reference frequency: zero or inside the band
  function automatic logic freq_legal(input logic [15:0] f);
    freq_legal = (f == rx_props_pkg::REF_FREQ_OFF) ||
                 (f >= rx_props_pkg::REF_FREQ_MIN &&
                  f <= rx_props_pkg::REF_FREQ_MAX);
  endfunction

  logic [15:0]          irq_src_q;
  logic [15:0]          irq_src_d;
  logic [15:0]          ref_freq_q;
  logic [15:0]          ref_freq_d;
  logic [DIVIDER_W-1:0] divider_q;
  logic [DIVIDER_W-1:0] divider_d;
  logic [15:0]          limit_q;
  logic [15:0]          limit_d;
  logic [7:0]           status_q;
  logic [7:0]           status_d;
  logic [15:0]          rdata_q;
  logic                 done_q;
  logic                 trig_q;
  logic                 pin_q;
  logic                 pin_oe_q;
  logic                 rail_q;
  logic                 corr_en_q;

  // access decode
  wire req       = prop_wr_in | prop_rd_in;
  wire take      = req & powered_up_in;
  wire hit_src   = prop_addr_in == rx_props_pkg::ADDR_IRQ_SOURCE;
  wire hit_freq  = prop_addr_in == rx_props_pkg::ADDR_REF_FREQ;
  wire hit_div   = prop_addr_in == rx_props_pkg::ADDR_REF_DIVIDER;
  wire hit_lim   = prop_addr_in == rx_props_pkg::ADDR_TUNE_LIMIT;
  wire hit_any   = hit_src | hit_freq | hit_div | hit_lim;

  // value checks on writes
  wire freq_ok   = freq_legal(prop_wdata_in);
  wire div_ok    = prop_wdata_in[15:DIVIDER_W] == '0 &&
                   prop_wdata_in[DIVIDER_W-1:0] >=
                   rx_props_pkg::DIVIDER_MIN;
  wire lim_ok    = prop_wdata_in <= rx_props_pkg::TUNE_LIMIT_MAX;
  wire bad_value = prop_wr_in & ((hit_freq & ~freq_ok) |
                                 (hit_div & ~div_ok) |
                                 (hit_lim & ~lim_ok));
  wire bad_req   = req & (~powered_up_in | ~hit_any | bad_value);

  // write strobes per property
  wire wr_ok     = take & prop_wr_in & ~bad_value;
  wire wr_src    = wr_ok & hit_src;
  wire wr_freq   = wr_ok & hit_freq;
  wire wr_div    = wr_ok & hit_div;
  wire wr_lim    = wr_ok & hit_lim;

  // writable enable bits, alert bits exist only on that variant
  wire [15:0] src_mask = rx_props_pkg::IRQ_WRITE_MASK &
                         (HAS_ALERT ? 16'hFFFF
                                    : ~rx_props_pkg::IRQ_ALERT_BITS);

  // interrupt source register, power-up loads the accept enable
  always_comb begin
    irq_src_d = irq_src_q;
    if (wr_src) begin
      irq_src_d = prop_wdata_in & src_mask;
    end
    if (powerup_cmd_in) begin
      irq_src_d[rx_props_pkg::BIT_ACCEPT] = powerup_accept_en_in;
    end
  end

  // remaining property next values
  assign ref_freq_d = wr_freq ? prop_wdata_in : ref_freq_q;
  assign divider_d  = wr_div ? prop_wdata_in[DIVIDER_W-1:0] : divider_q;
  assign limit_d    = wr_lim ? prop_wdata_in : limit_q;

  // read data selection, unmapped reads as zero
  wire [15:0] div_wide = {{(16-DIVIDER_W){1'b0}}, divider_q};
  wire [15:0] rd_sel   = hit_src  ? irq_src_q
                       : hit_freq ? ref_freq_q
                       : hit_div  ? div_wide
                       : hit_lim  ? limit_q
                       : 16'h0000;

  // status events: accept after each access, error on a bad one
  wire [7:0] ev_int = {done_q, bad_req, 6'b000000};
  wire [7:0] ev_all = (event_set_in | ev_int) &
                      rx_props_pkg::STATUS_USED;
  wire [7:0] clr_all = status_clear_in |
                       {take, 7'b0000000};

  // set wins over clear
  assign status_d = (status_q & ~clr_all) | ev_all;

  // effective enables and repeats per status bit
  wire [7:0] en_eff = irq_src_q[7:0] &
                      (WB_REV_2P0 ? ~rx_props_pkg::IRQ_SQ_ENABLE
                                  : 8'hFF);
  wire [7:0] rep_v  = {4'h0,
                       irq_src_q[rx_props_pkg::REPEAT_MSB:
                                 rx_props_pkg::REPEAT_LSB]};
  wire [7:0] trig_v = ev_all & en_eff & (~status_q | rep_v);

  // pin is the interrupt line while any effective source enable is set
  wire irq_mode = |en_eff;
  wire pin_d    = irq_mode ? ~trig_q : gpo_level_in;
  wire pin_oe_d = irq_mode | gpo_enable_in;

  // property registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_src_q  <= rx_props_pkg::RST_IRQ_SOURCE;
      ref_freq_q <= rx_props_pkg::RST_REF_FREQ;
      divider_q  <= rx_props_pkg::RST_REF_DIVIDER;
      limit_q    <= rx_props_pkg::RST_TUNE_LIMIT;
    end else begin
      irq_src_q  <= irq_src_d;
      ref_freq_q <= ref_freq_d;
      divider_q  <= divider_d;
      limit_q    <= limit_d;
    end
  end

  // access answer and status byte
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q  <= 16'h0000;
      done_q   <= 1'b0;
      status_q <= 8'h00;
    end else begin
      rdata_q  <= (take & prop_rd_in) ? rd_sel : rdata_q;
      done_q   <= req;
      status_q <= status_d;
    end
  end

  // interrupt pulse lags the flag by one cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_q   <= 1'b0;
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      trig_q   <= |trig_v;
      pin_q    <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // correction enable and rail indicator
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      corr_en_q <= 1'b0;
      rail_q    <= 1'b0;
    end else begin
      corr_en_q <= ref_freq_q != rx_props_pkg::REF_FREQ_OFF;
      rail_q    <= tune_error_in > limit_q;
    end
  end

  // external reference divided down to the internal tick
  ref_divider #(
    .WIDTH      (DIVIDER_W)
  ) u_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ext_ref_in (ext_ref_clk_in),
    .divide_in  (divider_q),
    .tick_out   (ref_tick_out)
  );

  assign prop_rdata_out        = rdata_q;
  assign prop_done_out         = done_q;
  assign status_out            = status_q;
  assign irq_pin_out           = pin_q;
  assign irq_pin_oe_out        = pin_oe_q;
  assign correction_enable_out = corr_en_q;
  assign rail_out              = rail_q;

  // checks on the flag to pin sequence
  sequence s_flag_trig;
    |(ev_all & en_eff & (~status_q | rep_v));
  endsequence

  sequence s_pin_low;
    trig_q ##1 (irq_pin_out == 1'b0);
  endsequence

  // pin level comes from the mode one cycle earlier
  localparam logic [7:0] STATUS_CHK = rx_props_pkg::STATUS_USED;
  property p_irq_after_flag;
    @(posedge sys_clk_in) disable iff (rst_in)
      ($past(irq_mode) && irq_pin_oe_out && !irq_pin_out)
      |-> $past(trig_q) && |($past(status_q) & STATUS_CHK);
  endproperty
  a_irq_after_flag: assert property (p_irq_after_flag)
    else $error("interrupt pin low without a set flag");

  property p_trig_to_pin;
    @(posedge sys_clk_in) disable iff (rst_in)
      (s_flag_trig ##1 irq_mode) |-> s_pin_low;
  endproperty
  a_trig_to_pin: assert property (p_trig_to_pin)
    else $error("enabled source did not pulse the pin");

  property p_status_unused;
    @(posedge sys_clk_in) disable iff (rst_in)
      (status_out & ~rx_props_pkg::STATUS_USED) == 8'h00;
  endproperty
  a_status_unused: assert property (p_status_unused)
    else $error("unused status bit set");

  property p_reserved_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
      (irq_src_q & ~rx_props_pkg::IRQ_WRITE_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved enable bit set");

  property p_powerup_accept;
    @(posedge sys_clk_in) disable iff (rst_in)
      powerup_cmd_in |=>
        irq_src_q[rx_props_pkg::BIT_ACCEPT] == $past(powerup_accept_en_in);
  endproperty
  a_powerup_accept: assert property (p_powerup_accept)
    else $error("accept enable not loaded at power-up");

  property p_no_repeat;
    @(posedge sys_clk_in) disable iff (rst_in)
      (status_q[0] && !irq_src_q[rx_props_pkg::REPEAT_LSB]) |-> !trig_v[0];
  endproperty
  a_no_repeat: assert property (p_no_repeat)
    else $error("repeat interrupt while repeat is off");

  property p_rev_sq_off;
    @(posedge sys_clk_in) disable iff (rst_in)
      WB_REV_2P0 |-> !trig_v[3];
  endproperty
  a_rev_sq_off: assert property (p_rev_sq_off)
    else $error("signal quality interrupt on revision 2.0");

  property p_accept_after_access;
    @(posedge sys_clk_in) disable iff (rst_in)
      take |=> prop_done_out ##1 status_out[rx_props_pkg::BIT_ACCEPT];
  endproperty
  a_accept_after_access: assert property (p_accept_after_access)
    else $error("accept flag not set after access");

  property p_freq_legal;
    @(posedge sys_clk_in) disable iff (rst_in)
      freq_legal(ref_freq_q) && divider_q >= rx_props_pkg::DIVIDER_MIN;
  endproperty
  a_freq_legal: assert property (p_freq_legal)
    else $error("illegal reference setting stored");

  property p_rail;
    @(posedge sys_clk_in) disable iff (rst_in)
      ##1 rail_out == ($past(tune_error_in) > $past(limit_q));
  endproperty
  a_rail: assert property (p_rail)
    else $error("rail indicator disagrees with limit");

  property p_pin_owned;
    @(posedge sys_clk_in) disable iff (rst_in)
      irq_mode |=> irq_pin_oe_out;
  endproperty
  a_pin_owned: assert property (p_pin_owned)
    else $error("interrupt pin not driven in interrupt mode");

endmodule

// *** bench/host_model.sv ***
// host controller model: issues one property access at a time
// assumes the bench owns the clock and powers the device before use
module host_model (
  // clock
  input  wire logic        sys_clk_in,
  // answer and status byte from the device
  input  wire logic [7:0]  status_in,
  input  wire logic        done_in,
  // property request toward the device
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] addr_out,
  output logic      [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle request lines
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end

  // request for one edge, then wait for the accept flag before returning
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [15:0] d, output logic ok);
    int n;
    @(negedge sys_clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge sys_clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    ok = done_in;
    n = 0;
    // next command only once the device can take it
    while (status_in[7] !== 1'b1 && n < 8) begin
      @(negedge sys_clk_in);
      n++;
    end
    ok = ok & (n < 8);
  endtask
endmodule

// *** bench/rx_irq_internal_reference_clock_properties_test.sv ***
// self-checking bench for the receiver property bank
// assumes rx_props_pkg is compiled first; host_model drives accesses
module rx_irq_internal_reference_clock_properties_test;
  timeunit 1ns;
  timeprecision 1ns;

  // design connections
  logic        clk, rst, powered, pu_cmd, pu_en, wr, rd, done;
  logic        gpo_en, gpo_lvl, irq, oe, irq2, ext_ref, tick, corr_en;
  logic        rail;
  logic [15:0] addr, wdata, rdata, tune_err, lim, w16;
  logic [7:0]  ev, clr, status;
  // bench state and reference model
  logic [15:0] model [logic [15:0]];
  logic [31:0] seed = 32'h00002A91;
  logic [31:0] x;
  logic [7:0]  refcnt = 8'h00;
  int          mismatches = 0;
  int          checks_done = 0;
  int          n1, n2;
  int          srcs [5] = '{0, 1, 2, 3, 6};
  logic [15:0] divs [3] = '{16'h0001, 16'h0003, 16'h0007};
  logic [15:0] fq [5] = '{16'h7999, 16'h799A, 16'h8666, 16'h8667, 16'h0000};
  logic [15:0] dv [4] = '{16'h0FFF, 16'h0000, 16'h1000, 16'h0001};
  logic [15:0] rnd_addr [4] = '{rx_props_pkg::ADDR_IRQ_SOURCE,
    rx_props_pkg::ADDR_REF_FREQ, rx_props_pkg::ADDR_TUNE_LIMIT, 16'h0002};

  // device under test and a second variant without alert, revision 2.0
  rx_props uut (.sys_clk_in(clk), .rst_in(rst), .powered_up_in(powered),
    .powerup_cmd_in(pu_cmd), .powerup_accept_en_in(pu_en), .prop_wr_in(wr),
    .prop_rd_in(rd), .prop_addr_in(addr), .prop_wdata_in(wdata),
    .prop_rdata_out(rdata), .prop_done_out(done), .event_set_in(ev),
    .status_clear_in(clr), .status_out(status), .gpo_enable_in(gpo_en),
    .gpo_level_in(gpo_lvl), .irq_pin_out(irq), .irq_pin_oe_out(oe),
    .ext_ref_clk_in(ext_ref), .ref_tick_out(tick),
    .correction_enable_out(corr_en), .tune_error_in(tune_err),
    .rail_out(rail));
  rx_props #(.HAS_ALERT(1'b0), .WB_REV_2P0(1'b1)) uut_rev2 (
    .sys_clk_in(clk), .rst_in(rst), .powered_up_in(powered),
    .powerup_cmd_in(pu_cmd), .powerup_accept_en_in(pu_en), .prop_wr_in(wr),
    .prop_rd_in(rd), .prop_addr_in(addr), .prop_wdata_in(wdata),
    .prop_rdata_out(), .prop_done_out(), .event_set_in(ev),
    .status_clear_in(clr), .status_out(), .gpo_enable_in(gpo_en),
    .gpo_level_in(gpo_lvl), .irq_pin_out(irq2), .irq_pin_oe_out(),
    .ext_ref_clk_in(ext_ref), .ref_tick_out(), .correction_enable_out(),
    .tune_error_in(tune_err), .rail_out());
  host_model host (.sys_clk_in(clk), .status_in(status), .done_in(done),
    .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

  // clock and an external reference of four clock periods
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) refcnt <= refcnt + 8'h01;
  assign ext_ref = refcnt[1];

  // xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // value compare with counting
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // legality of an access, worked out from the field ranges
  function automatic logic legal(input logic w, input logic [15:0] a,
                                 input logic [15:0] d);
    if (!powered || !model.exists(a)) return 1'b0;
    if (!w || a == rx_props_pkg::ADDR_IRQ_SOURCE) return 1'b1;
    if (a == rx_props_pkg::ADDR_REF_FREQ)
      return d == 16'h0000 || (d >= 16'h799A && d <= 16'h8666);
    if (a == rx_props_pkg::ADDR_REF_DIVIDER)
      return d >= 16'h0001 && d <= 16'h0FFF;
    return d <= 16'h000F;
  endfunction

  // one access compared with the model; error flag cleared afterwards
  task automatic prop(input logic w, input logic [15:0] a,
                      input logic [15:0] d);
    logic ok;
    logic good;
    good = legal(w, a, d);
    host.access(w, a, d, ok);
    check("done", 16'h0001, {15'h0, ok});
    if (ok !== 1'b1)
      print_verdict();
    check("error flag", {15'h0, !good}, {15'h0, status[6]});
    if (w && good)
      model[a] = d & (a == rx_props_pkg::ADDR_IRQ_SOURCE ?
                      rx_props_pkg::IRQ_WRITE_MASK : 16'hFFFF);
    if (!w)
      check("read data", good ? model[a] : 16'h0000, rdata);
    check("correction", {15'h0, model[rx_props_pkg::ADDR_REF_FREQ] != 0},
          {15'h0, corr_en});
    if (!good) begin
      clr = 8'h40;
      @(negedge clk);
      clr = 8'h00;
    end
  endtask

  // count low pin samples of both variants over four cycles
  task automatic count_low();
    n1 = 0;
    n2 = 0;
    repeat (4) begin
      @(negedge clk);
      n1 += int'(irq === 1'b0);
      n2 += int'(irq2 === 1'b0);
    end
  endtask

  // one status event, flag first, then expected pulse counts
  task automatic fire(input int k, input int e1, input int e2);
    ev = 8'h01 << k;
    @(negedge clk);
    ev = 8'h00;
    check("status bit", 16'h0001, {15'h0, status[k]});
    check("pin before flag", 16'h0001, {15'h0, irq});
    count_low();
    check("pulses", 16'(e1), 16'(n1));
    check("pulses rev2", 16'(e2), 16'(n2));
  endtask

  // counts and verdict
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    powered = 1'b1;
    pu_cmd = 1'b0;
    pu_en = 1'b0;
    ev = 8'h00;
    clr = 8'h00;
    gpo_en = 1'b0;
    gpo_lvl = 1'b1;
    tune_err = 16'h0000;
    model[rx_props_pkg::ADDR_IRQ_SOURCE] = 16'h0000;
    model[rx_props_pkg::ADDR_REF_FREQ] = 16'h8000;
    model[rx_props_pkg::ADDR_REF_DIVIDER] = 16'h0001;
    model[rx_props_pkg::ADDR_TUNE_LIMIT] = 16'h000A;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    // reset values, unmapped read, default rail limit
    foreach (model[a]) prop(1'b0, a, 16'h0000);
    prop(1'b0, 16'h0002, 16'h0000);
    tune_err = 16'h000B;
    repeat (3) @(negedge clk);
    check("rail default", 16'h0001, {15'h0, rail});
    // divided reference: four ticks per window of four periods
    foreach (divs[j]) begin
      prop(1'b1, rx_props_pkg::ADDR_REF_DIVIDER, divs[j]);
      repeat (8 * divs[j]) @(negedge clk);
      n1 = 0;
      repeat (16 * divs[j]) begin
        @(negedge clk);
        n1 += int'(tick === 1'b1);
      end
      check("ticks", 16'h0004, 16'(n1));
    end
    // field boundaries, refusal when unpowered, random words
    foreach (fq[j]) prop(1'b1, rx_props_pkg::ADDR_REF_FREQ, fq[j]);
    foreach (dv[j]) prop(1'b1, rx_props_pkg::ADDR_REF_DIVIDER, dv[j]);
    prop(1'b1, rx_props_pkg::ADDR_TUNE_LIMIT, 16'h0010);
    powered = 1'b0;
    prop(1'b1, rx_props_pkg::ADDR_TUNE_LIMIT, 16'h0003);
    powered = 1'b1;
    for (int i = 0; i < 20; i++) begin
      x = rnd();
      prop(1'b1, rnd_addr[x[17:16]], x[15:0]);
      prop(1'b0, rnd_addr[x[17:16]], 16'h0000);
    end
    prop(1'b1, rx_props_pkg::ADDR_IRQ_SOURCE, 16'h0000);
    // power-up loads the accept enable; accept flag then pulses the pin low
    pu_en = 1'b1;
    pu_cmd = 1'b1;
    @(negedge clk);
    pu_cmd = 1'b0;
    model[rx_props_pkg::ADDR_IRQ_SOURCE][7] = 1'b1;
    prop(1'b0, rx_props_pkg::ADDR_IRQ_SOURCE, 16'h0000);
    count_low();
    check("accept pulse", 16'h0001, 16'(n1));
    prop(1'b1, rx_props_pkg::ADDR_IRQ_SOURCE, 16'h0000);
    prop(1'b0, rx_props_pkg::ADDR_IRQ_SOURCE, 16'h0000);
    // each source except accept disabled, enabled, then enabled again, with repeat on sources 0 to 3
    foreach (srcs[j])
      for (int r = 0; r < 3; r++) begin
        w16 = (16'(r > 0) << srcs[j]) | (16'(r == 2 && srcs[j] < 4)
              << (srcs[j] + 8));
        prop(1'b1, rx_props_pkg::ADDR_IRQ_SOURCE, w16);
        fire(srcs[j], int'(r > 0), int'(r > 0 && srcs[j] != 2 &&
             srcs[j] != 3));
        fire(srcs[j], int'(r == 2 && srcs[j] < 4), int'(r == 2 &&
             srcs[j] < 2));
        // leave no event flag set for the next access
        clr = 8'h4F;
        @(negedge clk);
        clr = 8'h00;
      end
    // shared pin: general output unless an interrupt enable is set
    for (int i = 0; i < 8; i++) begin
      prop(1'b1, rx_props_pkg::ADDR_IRQ_SOURCE, 16'(i % 2));
      x = rnd();
      gpo_en = x[0];
      gpo_lvl = x[1];
      repeat (2) @(negedge clk);
      check("pin enable", {15'h0, i % 2 == 1 || x[0]}, {15'h0, oe});
      check("pin level", {15'h0, i % 2 == 1 || x[1]}, {15'h0, irq});
    end
    // rail indicator around the programmed limit
    for (int i = 0; i < 12; i++) begin
      x = rnd();
      lim = {12'h000, x[3:0]};
      prop(1'b1, rx_props_pkg::ADDR_TUNE_LIMIT, lim);
      tune_err = lim + 16'(i % 3) - 16'h0001;
      repeat (3) @(negedge clk);
      check("rail", {15'h0, tune_err > lim}, {15'h0, rail});
    end
    print_verdict();
  end
endmodule
